// *** verif/irq_source_pending_mode_tb.sv ***
// Self-checking bench for the interrupt front end.
// Assumes the zero-wait APB slave and two-edge request path of the top.
`timescale 1ns/100ps
module irq_source_pending_mode_tb
   import ispm_pkg::*;
;
   logic        sys_clk_in = 1'b0;
   logic        rst_in     = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = '0, pwdata = '0, prdata, src_req = '0, mask = '0, normal_req;
   logic        pready, pslverr, fiq_req, irq;
   logic [31:0] rd;
   logic        err;
   int          fails = 0, n_checks = 0, cycles = 0, fiq_n, irq_n;

   ispm_top dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .src_req_in(src_req), .source_mask_bits_in(mask),
      .fiq_req_out(fiq_req), .normal_req_out(normal_req), .irq_out(irq));
   ispm_core_model core (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .fiq_in(fiq_req),
      .normal_in(normal_req), .fiq_entries_out(fiq_n), .irq_entries_out(irq_n));

   initial
   begin
      forever #2 sys_clk_in = ~sys_clk_in;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Cuts a hang short
   always @(posedge sys_clk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         fails++;
      end
   endtask

   // One APB transfer; held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk_in);
      penable <= 1'b1;
      do @(posedge sys_clk_in); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, '0);
      chk(rd, exp);
      chk({31'h0, err}, 32'h0);
   endtask

   // One-cycle request, then time for latch, output and event status
   task automatic pulse(input logic [31:0] v);
      @(posedge sys_clk_in);
      src_req <= v;
      @(posedge sys_clk_in);
      src_req <= '0;
      repeat (4) @(posedge sys_clk_in);
   endtask

   task automatic t_reset();
      rd_chk(ISPM_ADDR_LATCH, 32'h0000_0000);
      rd_chk(ISPM_ADDR_MODE, 32'h0000_0000);
      chk({31'h0, fiq_req}, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_latch();
      mask <= 32'hFFFF_FFFF;
      pulse(32'h0001_0008);
      rd_chk(ISPM_ADDR_LATCH, 32'h0000_0008);
      chk(normal_req, 32'h0000_0000);
      mask <= 32'h0000_0000;
      repeat (4) @(posedge sys_clk_in);
      chk(normal_req, 32'h0000_0008);
      chk(irq_n, 1);
      rd_chk(ISPM_ADDR_LATCH, 32'h0000_0008);
      $display("test latch done");
   endtask

   task automatic t_clear();
      pulse(32'h0000_0020);
      apb(1'b1, ISPM_ADDR_LATCH, 32'h0000_0008);
      rd_chk(ISPM_ADDR_LATCH, 32'h0000_0020);
      apb(1'b1, ISPM_ADDR_LATCH, 32'h0000_0020);
      rd_chk(ISPM_ADDR_LATCH, 32'h0000_0000);
      $display("test clear done");
   endtask

   task automatic t_mode();
      apb(1'b1, ISPM_ADDR_MODE, 32'h0000_0020);
      rd_chk(ISPM_ADDR_MODE, 32'h0000_0000);
      pulse(32'h0000_0020);
      chk({31'h0, fiq_req}, 32'h1);
      chk(normal_req, 32'h0000_0000);
      chk(fiq_n, 1);
      rd_chk(ISPM_ADDR_STATUS, 32'h0000_0003);
      apb(1'b1, ISPM_ADDR_LATCH, 32'h0000_0020);
      repeat (3) @(posedge sys_clk_in);
      chk({31'h0, fiq_req}, 32'h0);
      apb(1'b1, ISPM_ADDR_MODE, 32'h0000_0000);
      $display("test mode done");
   endtask

   task automatic t_events();
      apb(1'b1, ISPM_ADDR_CLEAR, 32'h0000_0007);
      apb(1'b1, ISPM_ADDR_ENABLE, 32'h0000_0001);
      rd_chk(ISPM_ADDR_ENABLE, 32'h0000_0001);
      pulse(32'h0000_0002);
      chk({31'h0, irq}, 32'h1);
      rd_chk(ISPM_ADDR_STATUS, 32'h0000_0001);
      apb(1'b1, ISPM_ADDR_ENABLE, 32'h0000_0000);
      repeat (2) @(posedge sys_clk_in);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, ISPM_ADDR_CLEAR, 32'h0000_0001);
      apb(1'b1, ISPM_ADDR_ENABLE, 32'h0000_0007);
      repeat (2) @(posedge sys_clk_in);
      chk({31'h0, irq}, 32'h0);
      rd_chk(ISPM_ADDR_CLEAR, 32'h0000_0000);
      apb(1'b1, ISPM_ADDR_LATCH, 32'h0000_0002);
      apb(1'b1, ISPM_ADDR_MODE, 32'h0000_0003);
      rd_chk(ISPM_ADDR_STATUS, 32'h0000_0004);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, ISPM_ADDR_MODE, 32'h0000_0000);
      apb(1'b0, 32'h1440_0010, '0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0000_0000);
      chk(irq_n, 2);
      $display("test events done");
   endtask

   initial
   begin
      repeat (16) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      t_reset();
      t_latch();
      t_clear();
      t_mode();
      t_events();
      give_verdict();
   end
endmodule // irq_source_pending_mode_tb

// *** verif/ispm_core_model.sv ***
// Core-side model: counts entries on the fast and normal request lines.
// Assumes level requests synchronous to sys_clk_in.
`timescale 1ns/100ps
module ispm_core_model
(
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   input  wire logic        fiq_in,
   input  wire logic [31:0] normal_in,
   output int               fiq_entries_out,
   output int               irq_entries_out
);
   logic fiq_q;
   logic irq_q;
   // Counts rising edges only; a held level is one entry
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         fiq_q           <= 1'b0;
         irq_q           <= 1'b0;
         fiq_entries_out <= 0;
         irq_entries_out <= 0;
      end
      else
      begin
         fiq_q <= fiq_in;
         irq_q <= |normal_in;
         if (fiq_in && !fiq_q)
            fiq_entries_out <= fiq_entries_out + 1;
         if ((|normal_in) && !irq_q)
            irq_entries_out <= irq_entries_out + 1;
      end
   end
endmodule // ispm_core_model

// *** verilog/ispm_apb_slave.sv ***
// APB slave decode for the interrupt front end: strobes, read capture, error.
// Assumes an APB master on sys_clk_in; zero-wait access phase.
`timescale 1ns/100ps
module ispm_apb_slave
   import ispm_pkg::*;
(
   input  wire logic                     sys_clk_in,
   input  wire logic                     rst_in,
   input  wire logic                     psel_in,
   input  wire logic                     penable_in,
   input  wire logic                     pwrite_in,
   input  wire logic [31:0]              paddr_in,
   output logic      [ISPM_NUM_REGS-1:0] wr_sel_out,
   output logic      [ISPM_NUM_REGS-1:0] rd_sel_out,
   output logic                          pready_out,
   output logic                          pslverr_out
);

   logic [ISPM_NUM_REGS-1:0] hit;
   logic                     setup_phase;
   logic                     access_phase;
   logic                     next_err;
   logic                     err;

   always_comb
   begin
      hit[ISPM_SEL_LATCH]  = ispm_addr_hit(paddr_in, ISPM_ADDR_LATCH);
      hit[ISPM_SEL_MODE]   = ispm_addr_hit(paddr_in, ISPM_ADDR_MODE);
      hit[ISPM_SEL_STATUS] = ispm_addr_hit(paddr_in, ISPM_ADDR_STATUS);
      hit[ISPM_SEL_ENABLE] = ispm_addr_hit(paddr_in, ISPM_ADDR_ENABLE);
      hit[ISPM_SEL_CLEAR]  = ispm_addr_hit(paddr_in, ISPM_ADDR_CLEAR);
      setup_phase  = psel_in && !penable_in;
      access_phase = psel_in && penable_in;
      // Writes act only at the completing access edge
      wr_sel_out   = (access_phase && pwrite_in) ? hit : '0;
      // Read data is captured at the setup edge so prdata comes from a flop
      rd_sel_out   = (setup_phase && !pwrite_in) ? hit : '0;
      next_err     = setup_phase ? (hit == '0) : err;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         err <= 1'b0;
      else
         err <= next_err;
   end

   assign pready_out  = access_phase;
   assign pslverr_out = access_phase && err;

endmodule // ispm_apb_slave

// *** verilog/ispm_latch_bank.sv ***
// Sticky per-source request latch, write-one-to-clear.
// Assumes requests come from logic on sys_clk_in, so no synchroniser.
`timescale 1ns/100ps
module ispm_latch_bank
   import ispm_pkg::*;
(
   input  wire logic                    sys_clk_in,
   input  wire logic                    rst_in,
   input  wire logic [ISPM_NUM_SRC-1:0] set_in,
   input  wire logic [ISPM_NUM_SRC-1:0] clr_in,
   output logic      [ISPM_NUM_SRC-1:0] latch_out,
   output logic                         new_set_out
);

   logic [ISPM_NUM_SRC-1:0] next_latch;

   always_comb
   begin
      // Set wins over a clear in the same cycle; reserved bit never sets
      next_latch  = ((latch_out & ~clr_in) | set_in) & ~ISPM_RSVD_MASK;
      new_set_out = ((set_in & ~latch_out & ~ISPM_RSVD_MASK) != '0);
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         latch_out <= ISPM_LATCH_RESET;
      else
         latch_out <= next_latch;
   end

endmodule // ispm_latch_bank

// *** verilog/ispm_pkg.sv ***
// Package for the interrupt source latch and fast-path select front end.
// Assumes a 32-bit APB register bus and one system clock.
package ispm_pkg;

   localparam int          ISPM_NUM_SRC      = 32;
   localparam int          ISPM_RSVD_BIT     = 16;
   localparam logic [31:0] ISPM_RSVD_MASK    = 32'h0001_0000;

   // Register byte addresses
   localparam logic [31:0] ISPM_ADDR_LATCH   = 32'h1440_0000;
   localparam logic [31:0] ISPM_ADDR_MODE    = 32'h1440_0004;
   localparam logic [31:0] ISPM_ADDR_STATUS  = 32'h1440_0040;
   localparam logic [31:0] ISPM_ADDR_ENABLE  = 32'h1440_0044;
   localparam logic [31:0] ISPM_ADDR_CLEAR   = 32'h1440_0048;

   // Register select indices
   localparam int          ISPM_NUM_REGS     = 5;
   localparam int          ISPM_SEL_LATCH    = 0;
   localparam int          ISPM_SEL_MODE     = 1;
   localparam int          ISPM_SEL_STATUS   = 2;
   localparam int          ISPM_SEL_ENABLE   = 3;
   localparam int          ISPM_SEL_CLEAR    = 4;

   // Reset values
   localparam logic [31:0] ISPM_LATCH_RESET  = 32'h0000_0000;
   localparam logic [31:0] ISPM_MODE_RESET   = 32'h0000_0000;
   localparam logic [31:0] ISPM_ZERO_WORD    = 32'h0000_0000;

   // Event status layout
   localparam int          ISPM_EVT_W        = 3;
   localparam int          ISPM_EVT_LATCHED  = 0;
   localparam int          ISPM_EVT_FAST     = 1;
   localparam int          ISPM_EVT_CONFLICT = 2;
   localparam logic [2:0]  ISPM_EVT_RESET    = 3'h0;

   function automatic logic ispm_addr_hit(input logic [31:0] addr, input logic [31:0] reg_addr);
      return addr == reg_addr;
   endfunction

   // More than one bit set in a word
   function automatic logic ispm_multi_hot(input logic [31:0] word);
      return (word & (word - 32'h0000_0001)) != 32'h0000_0000;
   endfunction

endpackage

// *** verilog/ispm_top.sv ***
// Interrupt front end: source request latch, fast-path select, event status.
// Assumes same-clock peripheral requests, mask bits from the mask register,
// and a priority arbiter downstream fed by normal_req_out.
//
// How it works
// - Thirty-two bit source latch, one bit per source; bit 16 unused.
// - A raised source request sets its latch bit, which then stays set.
// - Latch bits set regardless of the mask bits.
// - The priority arbiter has no path into the latch bits.
// - A latch bit left at one keeps requesting as if new.
// - Writing the latch clears bits written one, keeps bits written zero.
// - Reading the latch returns every source still awaiting service.
// - Latch resets to all zeros.
// - Mode splits latched requests into one fast and the normal requests.
// - Thirty-two bit mode register; one selects fast path, zero normal.
// - Mode register is write-only; reads never return it.
// - Fast sources never reach the arbitrated pending or index path.
// - Mode register resets to all zeros, everything on normal path.
// - A masked source is not forwarded, though its latch bit stays.
`timescale 1ns/100ps
module ispm_top
   import ispm_pkg::*;
(
   input  wire logic                    sys_clk_in,
   input  wire logic                    rst_in,
   input  wire logic                    psel_in,
   input  wire logic                    penable_in,
   input  wire logic                    pwrite_in,
   input  wire logic [31:0]             paddr_in,
   input  wire logic [31:0]             pwdata_in,
   output logic      [31:0]             prdata_out,
   output logic                         pready_out,
   output logic                         pslverr_out,
   input  wire logic [ISPM_NUM_SRC-1:0] src_req_in,
   input  wire logic [ISPM_NUM_SRC-1:0] source_mask_bits_in,
   output logic                         fiq_req_out,
   output logic      [ISPM_NUM_SRC-1:0] normal_req_out,
   output logic                         irq_out
);

   logic [ISPM_NUM_REGS-1:0] wr_sel;
   logic [ISPM_NUM_REGS-1:0] rd_sel;
   logic [ISPM_NUM_SRC-1:0]  latch_clr;
   logic [ISPM_NUM_SRC-1:0]  source_request_latch;
   logic                     new_set;

   logic [ISPM_NUM_SRC-1:0]  fast_path_select;
   logic [ISPM_NUM_SRC-1:0]  next_fast_path_select;

   logic [ISPM_EVT_W-1:0]    evt_status;
   logic [ISPM_EVT_W-1:0]    next_evt_status;
   logic [ISPM_EVT_W-1:0]    evt_enable;
   logic [ISPM_EVT_W-1:0]    next_evt_enable;
   logic [ISPM_EVT_W-1:0]    evt_set;
   logic [ISPM_EVT_W-1:0]    evt_clr;

   logic [ISPM_NUM_SRC-1:0]  fast_live;
   logic [ISPM_NUM_SRC-1:0]  normal_live;
   logic                     next_fiq_req;
   logic [ISPM_NUM_SRC-1:0]  next_normal_req;
   logic                     next_irq;
   logic [31:0]              next_prdata;

   ispm_apb_slave u_apb
   (
      .sys_clk_in  (sys_clk_in),
      .rst_in      (rst_in),
      .psel_in     (psel_in),
      .penable_in  (penable_in),
      .pwrite_in   (pwrite_in),
      .paddr_in    (paddr_in),
      .wr_sel_out  (wr_sel),
      .rd_sel_out  (rd_sel),
      .pready_out  (pready_out),
      .pslverr_out (pslverr_out)
   );

   // Clear mask only from the bus; no arbiter input exists here
   assign latch_clr = wr_sel[ISPM_SEL_LATCH] ? pwdata_in : '0;

   ispm_latch_bank u_latch
   (
      .sys_clk_in  (sys_clk_in),
      .rst_in      (rst_in),
      .set_in      (src_req_in),        // Mask not consulted
      .clr_in      (latch_clr),
      .latch_out   (source_request_latch),
      .new_set_out (new_set)
   );

   // Mode register
   always_comb
   begin
      next_fast_path_select = fast_path_select;
      if (wr_sel[ISPM_SEL_MODE])
         next_fast_path_select = pwdata_in & ~ISPM_RSVD_MASK;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         fast_path_select <= ISPM_MODE_RESET;
      else
         fast_path_select <= next_fast_path_select;
   end

   // Routing to the core and to the arbiter
   always_comb
   begin
      fast_live       = source_request_latch & fast_path_select & ~source_mask_bits_in;
      normal_live     = source_request_latch & ~fast_path_select & ~source_mask_bits_in;
      next_fiq_req    = (fast_live != '0);
      next_normal_req = normal_live;
   end

   // Event status, enable and clear
   always_comb
   begin
      evt_set                    = '0;
      evt_set[ISPM_EVT_LATCHED]  = new_set;
      evt_set[ISPM_EVT_FAST]     = next_fiq_req && !fiq_req_out;
      // Flags a software slip; the hardware still stores the word, with bit 16 cleared
      evt_set[ISPM_EVT_CONFLICT] = wr_sel[ISPM_SEL_MODE] && ispm_multi_hot(pwdata_in & ~ISPM_RSVD_MASK);
      evt_clr                    = wr_sel[ISPM_SEL_CLEAR] ? pwdata_in[ISPM_EVT_W-1:0] : '0;
      next_evt_status            = (evt_status & ~evt_clr) | evt_set;
      next_evt_enable            = evt_enable;
      if (wr_sel[ISPM_SEL_ENABLE])
         next_evt_enable = pwdata_in[ISPM_EVT_W-1:0];
      next_irq                   = ((next_evt_status & next_evt_enable) != '0);
   end

   // Read data, captured at the setup edge
   always_comb
   begin
      next_prdata = prdata_out;
      if (rd_sel != '0)
      begin
         next_prdata = ISPM_ZERO_WORD;
         if (rd_sel[ISPM_SEL_LATCH])
            next_prdata = source_request_latch;
         if (rd_sel[ISPM_SEL_STATUS])
            next_prdata[ISPM_EVT_W-1:0] = evt_status;
         if (rd_sel[ISPM_SEL_ENABLE])
            next_prdata[ISPM_EVT_W-1:0] = evt_enable;
         // Mode and clear registers read as zero
      end
      else if (psel_in && !penable_in)
         next_prdata = ISPM_ZERO_WORD;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         evt_status <= ISPM_EVT_RESET;
         evt_enable <= ISPM_EVT_RESET;
      end
      else
      begin
         evt_status <= next_evt_status;
         evt_enable <= next_evt_enable;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         fiq_req_out    <= 1'b0;
         normal_req_out <= '0;
         irq_out        <= 1'b0;
      end
      else
      begin
         fiq_req_out    <= next_fiq_req;
         normal_req_out <= next_normal_req;
         irq_out        <= next_irq;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         prdata_out <= ISPM_ZERO_WORD;
      else
         prdata_out <= next_prdata;
   end

   // Checks
   default clocking chk_cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   logic [31:0] chk_req_live;
   assign chk_req_live = src_req_in & ~ISPM_RSVD_MASK;

   latch_set_a : assert property (
      (chk_req_live != '0) |=> ((source_request_latch & $past(chk_req_live)) == $past(chk_req_live)))
      else $error("raised source not latched");

   latch_hold_a : assert property (
      1'b1 |=> ((source_request_latch & $past(source_request_latch) & ~$past(latch_clr))
                == ($past(source_request_latch) & ~$past(latch_clr))))
      else $error("latch bit dropped without clear");

   w1c_clear_a : assert property (
      wr_sel[ISPM_SEL_LATCH] |=> ((source_request_latch & $past(pwdata_in & ~src_req_in)) == '0))
      else $error("write one did not clear latch bit");

   reserved_bit_a : assert property (
      !source_request_latch[ISPM_RSVD_BIT] && !fast_path_select[ISPM_RSVD_BIT])
      else $error("reserved bit set");

   fast_route_a : assert property (
      1'b1 |=> (fiq_req_out == $past((source_request_latch & fast_path_select & ~source_mask_bits_in) != '0)))
      else $error("fast request wrong");

   normal_route_a : assert property (
      1'b1 |=> ((normal_req_out & $past(fast_path_select | source_mask_bits_in)) == '0))
      else $error("fast or masked source on normal path");

   mode_hidden_a : assert property (
      (psel_in && !penable_in && !pwrite_in && ispm_addr_hit(paddr_in, ISPM_ADDR_MODE))
      |=> (prdata_out == ISPM_ZERO_WORD))
      else $error("mode register readable");

   latch_read_a : assert property (
      (psel_in && !penable_in && !pwrite_in && ispm_addr_hit(paddr_in, ISPM_ADDR_LATCH))
      |=> (prdata_out == $past(source_request_latch)))
      else $error("latch read mismatch");

   reset_clear_a : assert property (@(posedge sys_clk_in)
      $past(rst_in) |-> (source_request_latch == ISPM_LATCH_RESET && fast_path_select == ISPM_MODE_RESET))
      else $error("reset value wrong");

   irq_level_a : assert property (
      1'b1 |=> (irq_out == ((evt_status & evt_enable) != '0)))
      else $error("interrupt level wrong");

   // Register, bus and event checks
   w1c_keep_a : assert property (
      wr_sel[ISPM_SEL_LATCH]
      |=> ((source_request_latch & ~$past(pwdata_in))
           == (($past(source_request_latch) | $past(chk_req_live)) & ~$past(pwdata_in))))
      else $error("latch bit written zero changed");

   latch_rise_a : assert property (
      1'b1 |=> ((source_request_latch & ~$past(source_request_latch) & ~$past(chk_req_live)) == '0))
      else $error("latch bit set without a request");

   mode_write_a : assert property (
      wr_sel[ISPM_SEL_MODE] |=> (fast_path_select == ($past(pwdata_in) & ~ISPM_RSVD_MASK)))
      else $error("mode register write lost");

   mode_hold_a : assert property (
      !wr_sel[ISPM_SEL_MODE] |=> $stable(fast_path_select))
      else $error("mode register changed without a write");

   normal_fwd_a : assert property (
      1'b1 |=> (normal_req_out == $past(source_request_latch & ~fast_path_select & ~source_mask_bits_in)))
      else $error("normal request not forwarded");

   fiq_masked_a : assert property (
      1'b1 |=> (!fiq_req_out || ($past(fast_path_select & ~source_mask_bits_in) != '0)))
      else $error("fast request with every fast source masked");

   reset_outputs_a : assert property (@(posedge sys_clk_in)
      $past(rst_in) |-> (!fiq_req_out && normal_req_out == '0 && !irq_out && prdata_out == ISPM_ZERO_WORD))
      else $error("output not idle after reset");

   unmapped_read_a : assert property (
      (psel_in && !penable_in && !pwrite_in && rd_sel == '0) |=> (prdata_out == ISPM_ZERO_WORD))
      else $error("unmapped read returned data");

   bus_error_a : assert property (
      (psel_in && !penable_in && !pwrite_in && rd_sel == '0) ##1 (psel_in && penable_in) |-> pslverr_out)
      else $error("unmapped read answered without error");

   enable_write_a : assert property (
      wr_sel[ISPM_SEL_ENABLE] |=> (evt_enable == $past(pwdata_in[ISPM_EVT_W-1:0])))
      else $error("event enable write lost");

   event_sticky_a : assert property (
      1'b1 |=> ((evt_status & $past(evt_status & ~evt_clr)) == $past(evt_status & ~evt_clr)))
      else $error("event status dropped without clear");

   event_clear_a : assert property (
      wr_sel[ISPM_SEL_CLEAR] |=> ((evt_status & $past(pwdata_in[ISPM_EVT_W-1:0] & ~evt_set)) == '0))
      else $error("event clear did not clear");

   fast_event_a : assert property (
      (next_fiq_req && !fiq_req_out) |=> (fiq_req_out && evt_status[ISPM_EVT_FAST]))
      else $error("fast request rise not recorded");

   mode_conflict_a : assert property (
      (wr_sel[ISPM_SEL_MODE] && ispm_multi_hot(pwdata_in & ~ISPM_RSVD_MASK))
      |=> evt_status[ISPM_EVT_CONFLICT])
      else $error("multiple fast sources not flagged");

   latch_event_a : assert property (
      new_set |=> evt_status[ISPM_EVT_LATCHED])
      else $error("new latch bit not recorded");

endmodule // ispm_top
